/* rtl/fbc_pkg.sv */
// Purpose: Constants and types for the byte-mode flash command host
// Assumes: x8 bus, byte addresses as driven on the flash pins
// Notes: Timing counts in cycles of clk_sys at 100 MHz
`default_nettype none
package fbc_pkg;
  localparam int FBC_AW = 27;
  localparam int CLK_NS = 10;
  localparam int T_WE_LOW_NS = 35;
  localparam int T_WE_HIGH_NS = 20;
  localparam int T_READ_NS = 90;
  localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [11:0] ADDR_UNLK1 = 12'haaa;
  localparam logic [11:0] ADDR_UNLK2 = 12'h555;
  localparam logic [11:0] ADDR_CFI = 12'h0aa;
  localparam logic [7:0] OFS_MFR = 8'h00;
  localparam logic [7:0] OFS_DEV1 = 8'h02;
  localparam logic [7:0] OFS_DEV2 = 8'h1c;
  localparam logic [7:0] OFS_DEV3 = 8'h1e;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_SECV = 8'h06;
  localparam logic [7:0] D_UNLK1 = 8'haa;
  localparam logic [7:0] D_UNLK2 = 8'h55;
  localparam logic [7:0] D_RESET = 8'hf0;
  localparam logic [7:0] D_AUTOSEL = 8'h90;
  localparam logic [7:0] D_CFI = 8'h98;
  localparam logic [7:0] D_PROG = 8'ha0;
  localparam logic [7:0] D_WBUF = 8'h25;
  localparam logic [7:0] D_WCONF = 8'h29;
  localparam logic [7:0] D_BYPASS = 8'h20;
  localparam logic [7:0] D_ERASE = 8'h80;
  localparam logic [7:0] D_SECT = 8'h30;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_SUSP = 8'hb0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_SECSI = 8'h88;
  localparam logic [7:0] D_ZERO = 8'h00;
  localparam int SECT_LSB = 16;

  typedef enum logic [3:0] {
    FBC_READ = 4'h0, FBC_RESET = 4'h1, FBC_AUTOSEL = 4'h2, FBC_CFI = 4'h3,
    FBC_PROG = 4'h4, FBC_WBUF = 4'h5, FBC_WCONF = 4'h6, FBC_ABORT_RST = 4'h7,
    FBC_BYP_ENTER = 4'h8, FBC_BYP_PROG = 4'h9, FBC_BYP_SECT = 4'ha, FBC_BYP_CHIP = 4'hb,
    FBC_BYP_EXIT = 4'hc, FBC_CHIP_ERASE = 4'hd, FBC_SECT_ERASE = 4'he, FBC_MISC = 4'hf
  } fbc_op_t;

  // FBC_MISC selects by sub code: 0 suspend, 1 resume, 2 secured entry, 3 secured exit
  typedef struct packed {
    fbc_op_t op;
    logic [1:0] sub;
    logic [FBC_AW-1:0] addr;
    logic [7:0] data;
    logic [5:0] count;
  } fbc_req_t;

  typedef struct packed {
    logic [FBC_AW-1:0] addr;
    logic [7:0] data;
  } fbc_cyc_t;
endpackage
`default_nettype wire

/* rtl/fbc_host.sv */
// Purpose: Host that issues byte-mode flash command sequences on the pins
// Assumes: Single clk_sys domain; flash outputs sampled through 3 flops
// Notes: Buffer words are fed one per accepted load strobe
`default_nettype none
// Function
// - Array read is a bare read cycle
// - F0 anywhere returns device to reading
// - Program: AA, 55, A0, then data
// - Erase: six writes, ending 30 or 10
// - Buffer: unlocks, 25 sector, count minus one
// - Load addresses stay in one page
// - Buffer sequence totals 5 to 68 writes
// - 29 to sector commits the buffer
// - Abort reset: AA, 55, F0 to AAA
// - Bypass enter 20; two-write commands inside
// - Bypass exit is 90 then 00
// - B0 anywhere suspends program or erase
// - Secured sector entry 88, exit 90/00
// - ID query: unlocks, 90, then reads
module fbc_host
  import fbc_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire logic req_valid, // Command request
  output logic req_ready, // Host idle, takes request
  input wire fbc_pkg::fbc_req_t req, // Command request fields
  output logic load_ready, // Takes one buffer word
  input wire logic load_valid, // Buffer word offered
  input wire fbc_pkg::fbc_cyc_t load, // Buffer word slot and value
  output logic rd_valid, // Read data strobe
  output logic [7:0] rd_data, // Read data
  output logic [fbc_pkg::FBC_AW-1:0] fl_addr, // Flash address pins
  output logic [15:0] fl_dq_o, // Flash data out
  output logic fl_dq_oe, // Flash data drive enable
  input wire logic [15:0] fl_dq_i, // Flash data in
  output logic fl_ce_n, // Chip select, active low
  output logic fl_we_n, // Write strobe, active low
  output logic fl_oe_n // Output enable, active low
);
  import fbc_pkg::*;

  // ------------------------------------------------------------
  // Sequence table
  // ------------------------------------------------------------
  function automatic fbc_cyc_t cyc(input logic [11:0] a, input logic [7:0] d);
    cyc = '{addr: {{(FBC_AW-12){1'b0}}, a}, data: d};
  endfunction

  function automatic fbc_cyc_t at(input logic [FBC_AW-1:0] a, input logic [7:0] d);
    at = '{addr: a, data: d};
  endfunction

  // Returns step n of a sequence; rd flags a read step, last marks the end
  function automatic void step(input fbc_req_t r, input logic [6:0] n, output fbc_cyc_t c,
                               output logic rd, output logic last);
    logic [FBC_AW-1:0] sect;
    logic [FBC_AW-1:0] id;
    sect = r.addr & ~((FBC_AW'(1) << SECT_LSB) - FBC_AW'(1));
    id = '0;
    c = cyc(ADDR_UNLK1, D_UNLK1);
    rd = 1'b0;
    last = 1'b0;
    if (n == 7'd1) c = cyc(ADDR_UNLK2, D_UNLK2);
    unique case (r.op)
      FBC_READ: begin
        c = at(r.addr, D_ZERO);
        rd = 1'b1;
        last = 1'b1;
      end
      FBC_RESET: begin
        c = cyc(ADDR_UNLK1, D_RESET);
        last = 1'b1;
      end
      FBC_CFI: begin
        c = cyc(ADDR_CFI, D_CFI);
        last = 1'b1;
      end
      FBC_AUTOSEL: begin
        if (n == 7'd2) c = cyc(ADDR_UNLK1, D_AUTOSEL);
        if (n >= 7'd3) begin
          rd = 1'b1;
          unique case (r.sub)
            2'd0: id[7:0] = OFS_MFR;
            2'd1: id[7:0] = (n == 7'd3) ? OFS_DEV1 : (n == 7'd4) ? OFS_DEV2 : OFS_DEV3;
            2'd2: id = sect | FBC_AW'(OFS_PROT);
            2'd3: id[7:0] = OFS_SECV;
          endcase
          c = at(id, D_ZERO);
        end
        last = (r.sub == 2'd1) ? (n == 7'd5) : (n == 7'd3);
      end
      FBC_PROG: begin
        if (n == 7'd2) c = cyc(ADDR_UNLK1, D_PROG);
        if (n == 7'd3) c = at(r.addr, r.data);
        last = (n == 7'd3);
      end
      FBC_WBUF: begin
        if (n == 7'd2) c = at(sect, D_WBUF);
        if (n == 7'd3) c = at(sect, {2'b00, r.count});
        last = (n == 7'(r.count) + 7'd4);
        if (n >= 7'd4) c = at(r.addr, r.data);
      end
      FBC_WCONF: begin
        c = at(sect, D_WCONF);
        last = 1'b1;
      end
      FBC_ABORT_RST: begin
        if (n == 7'd2) c = cyc(ADDR_UNLK1, D_RESET);
        last = (n == 7'd2);
      end
      FBC_BYP_ENTER: begin
        if (n == 7'd2) c = cyc(ADDR_UNLK1, D_BYPASS);
        last = (n == 7'd2);
      end
      FBC_BYP_PROG: begin
        c = (n == 7'd0) ? cyc(ADDR_UNLK1, D_PROG) : at(r.addr, r.data);
        last = (n == 7'd1);
      end
      FBC_BYP_SECT: begin
        c = (n == 7'd0) ? cyc(ADDR_UNLK1, D_ERASE) : at(sect, D_SECT);
        last = (n == 7'd1);
      end
      FBC_BYP_CHIP: begin
        c = (n == 7'd0) ? cyc(ADDR_UNLK1, D_ERASE) : cyc(ADDR_UNLK1, D_CHIP);
        last = (n == 7'd1);
      end
      FBC_BYP_EXIT: begin
        c = (n == 7'd0) ? cyc(ADDR_UNLK1, D_AUTOSEL) : cyc(ADDR_UNLK1, D_ZERO);
        last = (n == 7'd1);
      end
      FBC_CHIP_ERASE, FBC_SECT_ERASE: begin
        if (n == 7'd2) c = cyc(ADDR_UNLK1, D_ERASE);
        if (n == 7'd4) c = cyc(ADDR_UNLK2, D_UNLK2);
        if (n == 7'd5) c = (r.op == FBC_CHIP_ERASE) ? cyc(ADDR_UNLK1, D_CHIP) : at(sect, D_SECT);
        last = (n == 7'd5);
      end
      FBC_MISC: begin
        unique case (r.sub)
          2'd0: c = cyc(ADDR_UNLK1, D_SUSP);
          2'd1: c = cyc(ADDR_UNLK1, D_RESUME);
          2'd2: if (n == 7'd2) c = cyc(ADDR_UNLK1, D_SECSI);
          2'd3: begin
            if (n == 7'd2) c = cyc(ADDR_UNLK1, D_AUTOSEL);
            if (n == 7'd3) c = cyc(ADDR_UNLK1, D_ZERO);
          end
        endcase
        last = (r.sub[1] == 1'b0) || (r.sub == 2'd2 ? n == 7'd2 : n == 7'd3);
      end
    endcase
  endfunction

  // ------------------------------------------------------------
  // Bus cycle engine
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    FBC_S_IDLE = 5'b00001, FBC_S_SETUP = 5'b00010, FBC_S_STROBE = 5'b00100,
    FBC_S_HOLD = 5'b01000, FBC_S_WAIT = 5'b10000
  } fbc_st_t;

  fbc_st_t st_q, st_d;
  fbc_req_t req_q, req_d;
  logic [6:0] n_q, n_d;
  logic [3:0] cnt_q, cnt_d;
  logic rd_q, rd_d, last_q, last_d;
  logic [FBC_AW-1:0] addr_q, addr_d;
  logic [7:0] dout_q, dout_d;
  logic ce_q, ce_d, we_q, we_d, oe_q, oe_d, drv_q, drv_d;
  logic rv_q, rv_d;
  logic [7:0] rdat_q, rdat_d;
  logic [7:0] sy1_q, sy2_q, sy3_q, syf_q, syf_d;
  fbc_cyc_t c_n;
  logic rd_n, last_n, is_load;

  // Step decoded from registered state, no loop through next-state logic
  always_comb begin
    step(req_q, n_q, c_n, rd_n, last_n);
  end

  // Buffer words of a buffered write come from the load port
  assign is_load = (req_q.op == FBC_WBUF) && (n_q >= 7'd4);
  assign req_ready = (st_q == FBC_S_IDLE);
  assign load_ready = (st_q == FBC_S_WAIT) && is_load;

  always_comb begin
    st_d = st_q;
    req_d = req_q;
    n_d = n_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    last_d = last_q;
    addr_d = addr_q;
    dout_d = dout_q;
    ce_d = ce_q;
    we_d = we_q;
    oe_d = oe_q;
    drv_d = drv_q;
    rv_d = 1'b0;
    rdat_d = rdat_q;
    // Pin value counts once the second and third flops agree
    syf_d = (sy2_q == sy3_q) ? sy3_q : syf_q;
    unique case (st_q)
      FBC_S_IDLE: begin
        if (req_valid) begin
          req_d = req;
          n_d = '0;
          st_d = FBC_S_WAIT;
        end
      end
      FBC_S_WAIT: begin
        // Load the cycle; address settles before the strobe falls
        if (!is_load || load_valid) begin
          addr_d = is_load ? load.addr : c_n.addr;
          dout_d = is_load ? load.data : c_n.data;
          rd_d = rd_n;
          last_d = last_n;
          ce_d = 1'b1;
          drv_d = !rd_n;
          cnt_d = 4'(WE_HIGH_CYC);
          st_d = FBC_S_SETUP;
        end
      end
      FBC_S_SETUP: begin
        cnt_d = cnt_q - 4'd1;
        if (cnt_q == 4'd1) begin
          we_d = !rd_q;
          oe_d = rd_q;
          cnt_d = rd_q ? 4'(READ_CYC + 3) : 4'(WE_LOW_CYC);
          st_d = FBC_S_STROBE;
        end
      end
      FBC_S_STROBE: begin
        cnt_d = cnt_q - 4'd1;
        if (cnt_q == 4'd1) begin
          we_d = 1'b0;
          oe_d = 1'b0;
          rv_d = rd_q;
          rdat_d = syf_q;
          cnt_d = 4'(WE_HIGH_CYC);
          st_d = FBC_S_HOLD;
        end
      end
      FBC_S_HOLD: begin
        cnt_d = cnt_q - 4'd1;
        if (cnt_q == 4'd1) begin
          ce_d = 1'b0;
          drv_d = 1'b0;
          n_d = n_q + 7'd1;
          st_d = last_q ? FBC_S_IDLE : FBC_S_WAIT;
        end
      end
      default: st_d = FBC_S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= FBC_S_IDLE;
      req_q <= '0;
      n_q <= '0;
      cnt_q <= '0;
      rd_q <= 1'b0;
      last_q <= 1'b0;
      addr_q <= '0;
      dout_q <= '0;
      ce_q <= 1'b0;
      we_q <= 1'b0;
      oe_q <= 1'b0;
      drv_q <= 1'b0;
      rv_q <= 1'b0;
      rdat_q <= '0;
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
      syf_q <= '0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      n_q <= n_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      last_q <= last_d;
      addr_q <= addr_d;
      dout_q <= dout_d;
      ce_q <= ce_d;
      we_q <= we_d;
      oe_q <= oe_d;
      drv_q <= drv_d;
      rv_q <= rv_d;
      rdat_q <= rdat_d;
      sy1_q <= fl_dq_i[7:0];
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      syf_q <= syf_d;
    end
  end

  assign fl_addr = addr_q;
  assign fl_dq_o = {8'h00, dout_q};
  assign fl_dq_oe = drv_q;
  assign fl_ce_n = !ce_q;
  assign fl_we_n = !we_q;
  assign fl_oe_n = !oe_q;
  assign rd_valid = rv_q;
  assign rd_data = rdat_q;
endmodule
`default_nettype wire

/* tb/fbc_chk.sv */
// Purpose: Pin protocol checks for fbc_host
// Assumes: Only the ports of fbc_host are seen
// Notes: Bound at the foot of this file
`default_nettype none
module fbc_chk
  import fbc_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic req_ready, // Host idle
  input wire logic rd_valid, // Read strobe
  input wire logic [fbc_pkg::FBC_AW-1:0] fl_addr, // Address pins
  input wire logic [15:0] fl_dq_o, // Data out
  input wire logic fl_dq_oe, // Data drive enable
  input wire logic fl_ce_n, // Chip select
  input wire logic fl_we_n, // Write strobe
  input wire logic fl_oe_n // Output enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_upper_lane_zero: assert property (fl_dq_oe |-> fl_dq_o[15:8] == 8'h00)
    else $error("upper data lane driven");
  a_we_pulse_stable: assert property ($fell(fl_we_n) |->
    (!fl_we_n && $stable(fl_addr) && $stable(fl_dq_o))[*4] ##1 fl_we_n)
    else $error("write strobe or its address moved");
  a_data_hold_rise: assert property ($rose(fl_we_n) |-> !fl_ce_n && fl_dq_oe && $stable(fl_dq_o))
    else $error("data not held past strobe rise");
  a_write_drives_bus: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n)
    else $error("write without drive or select");
  a_we_oe_apart: assert property (!fl_we_n |-> fl_oe_n)
    else $error("write and read strobes together");
  a_read_no_drive: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("bus driven during read");
  a_read_gives_data: assert property ($fell(fl_oe_n) |-> ##[10:14] rd_valid)
    else $error("read gave no data strobe");
  a_rd_one_pulse: assert property (rd_valid |=> !rd_valid)
    else $error("read strobe longer than one cycle");
  cover property ($fell(fl_we_n));
  cover property (rd_valid);
  cover property ($fell(req_ready));
endmodule
bind fbc_host fbc_chk fbc_chk_i (.clk_sys(clk_sys), .arst_n(arst_n), .req_ready(req_ready),
  .rd_valid(rd_valid), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
  .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
`default_nettype wire

/* tb/fbc_flash_model.sv */
// Purpose: Byte-mode flash device seen from its pins
// Assumes: Array content is a fixed function of address
// Notes: Logs every write cycle for the bench
`default_nettype none
module fbc_flash_model
  import fbc_pkg::*;
#(parameter logic [7:0] MFR_CODE = 8'h6b) // Arbitrary maker code
(
  input wire logic [fbc_pkg::FBC_AW-1:0] fl_addr, // Address pins
  input wire logic [15:0] fl_dq_o, // Data from host
  input wire logic fl_ce_n, // Chip select
  input wire logic fl_we_n, // Write strobe
  input wire logic fl_oe_n, // Output enable
  output logic [15:0] fl_dq_i // Data to host
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [FBC_AW-1:0] wa [0:255];
  logic [7:0] wd [0:255];
  logic [FBC_AW-1:0] lat_a;
  logic [7:0] rv;
  logic [7:0] last = 8'h00;
  logic asel = 1'b0;
  int n = 0;
  int unl = 0;
  wire logic wr_n = fl_we_n | fl_ce_n;
  always @(negedge wr_n) lat_a = fl_addr;
  always @(posedge wr_n) if ($time > 0) begin
    wa[n] = lat_a;
    wd[n] = fl_dq_o[7:0];
    if (unl == 2 && fl_dq_o[7:0] == D_AUTOSEL && lat_a[11:0] == ADDR_UNLK1) asel = 1'b1;
    if (fl_dq_o[7:0] == D_RESET || fl_dq_o[7:0] == D_ZERO) asel = 1'b0;
    // Any write off the unlock path restarts the prefix
    if (fl_dq_o[7:0] == D_UNLK1 && lat_a[11:0] == ADDR_UNLK1) unl = 1;
    else if (unl == 1 && fl_dq_o[7:0] == D_UNLK2 && lat_a[11:0] == ADDR_UNLK2) unl = 2;
    else unl = 0;
    n = n + 1;
  end
  always_comb rv = !asel ? fl_addr[7:0] ^ 8'h3c : fl_addr[7:0] == OFS_MFR ? MFR_CODE :
    fl_addr[7:0] == OFS_PROT ? 8'h00 : fl_addr[7:0] == OFS_SECV ? 8'h80 : fl_addr[7:0] ^ 8'h3c;
  always @(posedge fl_oe_n) last = rv;
  // Released bus shows the inverse of the last value
  assign fl_dq_i = (!fl_oe_n && !fl_ce_n) ? {8'h00, rv} : {8'hff, ~last};
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for fbc_host
// Assumes: Write log of the flash model and read strobe of fbc_host
// Notes: Each scenario checks its own pin cycles
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import fbc_pkg::*;
  localparam logic [7:0] MFR = 8'h6b; // Arbitrary maker code
  logic clk_sys = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_ready, load_ready, load_valid = 1'b0;
  logic rd_valid, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n;
  logic [7:0] rd_data, rd_last;
  logic [FBC_AW-1:0] fl_addr;
  logic [15:0] fl_dq_o, fl_dq_i;
  fbc_req_t req = '0;
  fbc_cyc_t load = '0;
  fbc_cyc_t wl [0:63];
  int bad_count = 0, check_count = 0, cyc = 0, base = 0, rd_cnt = 0;
  always #5 clk_sys = ~clk_sys;
  fbc_host fbc_host_i (.clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .load_ready(load_ready), .load_valid(load_valid), .load(load), .rd_valid(rd_valid),
    .rd_data(rd_data), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
  fbc_flash_model #(.MFR_CODE(MFR)) fbc_flash_model_i (.fl_addr(fl_addr), .fl_dq_o(fl_dq_o),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_i(fl_dq_i));
  always @(posedge clk_sys) begin
    cyc++;
    if (rd_valid === 1'b1) begin
      rd_cnt++;
      rd_last = rd_data;
    end
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cw(int i, logic [26:0] a, logic [7:0] d, bit ca = 1);
    if (ca) chk("write address", 32'(a), 32'(fbc_flash_model_i.wa[base + i]));
    chk("write data", 32'(d), 32'(fbc_flash_model_i.wd[base + i]));
  endtask
  task automatic pre(int i);
    cw(i, 27'haaa, D_UNLK1);
    cw(i + 1, 27'h555, D_UNLK2);
  endtask
  task automatic send(fbc_op_t op, logic [1:0] sub, logic [26:0] a, logic [7:0] d, logic [5:0] c, int nw);
    base = fbc_flash_model_i.n;
    req = '{op: op, sub: sub, addr: a, data: d, count: c};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
    for (int k = 0; op == FBC_WBUF && k <= int'(c); k++) begin
      while (load_ready !== 1'b1) @(posedge clk_sys) #1;
      load_valid = 1'b1;
      load = wl[k];
      @(posedge clk_sys) #1;
      load_valid = 1'b0;
    end
    @(posedge clk_sys) #1;
    while (req_ready !== 1'b1) @(posedge clk_sys) #1;
    chk("write count", 32'(nw), 32'(fbc_flash_model_i.n - base));
  endtask
  task automatic t_program_erase();
    send(FBC_PROG, 2'd0, 27'h5a1_2345, 8'hc3, 6'd0, 4);
    pre(0);
    cw(2, 27'haaa, D_PROG);
    cw(3, 27'h5a1_2345, 8'hc3);
    send(FBC_SECT_ERASE, 2'd0, 27'h123_4567, 8'h00, 6'd0, 6);
    pre(3);
    cw(2, 27'haaa, D_ERASE);
    cw(5, 27'h123_0000, D_SECT);
    send(FBC_CHIP_ERASE, 2'd0, 27'h0, 8'h00, 6'd0, 6);
    cw(5, 27'haaa, D_CHIP);
  endtask
  task automatic t_buffer();
    for (int k = 0; k < 64; k++) wl[k] = '{addr: 27'h123_4540 + 27'(k), data: 8'(k * 3)};
    send(FBC_WBUF, 2'd0, 27'h123_4540, 8'h00, 6'd63, 68);
    pre(0);
    cw(2, 27'h123_0000, D_WBUF);
    cw(3, 27'h123_0000, 8'd63);
    for (int k = 0; k < 64; k++) cw(4 + k, wl[k].addr, wl[k].data);
    send(FBC_WCONF, 2'd0, 27'h123_4540, 8'h00, 6'd0, 1);
    cw(0, 27'h123_0000, D_WCONF);
  endtask
  task automatic t_bypass_misc();
    send(FBC_BYP_ENTER, 2'd0, 27'h0, 8'h00, 6'd0, 3);
    cw(2, 27'haaa, D_BYPASS);
    send(FBC_BYP_PROG, 2'd0, 27'h2a0_0101, 8'h5e, 6'd0, 2);
    cw(0, 27'h0, D_PROG, 0);
    cw(1, 27'h2a0_0101, 8'h5e);
    send(FBC_BYP_SECT, 2'd0, 27'h2a0_0101, 8'h00, 6'd0, 2);
    cw(1, 27'h2a0_0000, D_SECT);
    send(FBC_BYP_CHIP, 2'd0, 27'h0, 8'h00, 6'd0, 2);
    cw(1, 27'h0, D_CHIP, 0);
    send(FBC_ABORT_RST, 2'd0, 27'h0, 8'h00, 6'd0, 3);
    cw(2, 27'haaa, D_RESET);
    send(FBC_BYP_EXIT, 2'd0, 27'h0, 8'h00, 6'd0, 2);
    cw(0, 27'h0, D_AUTOSEL, 0);
    cw(1, 27'h0, D_ZERO, 0);
    send(FBC_MISC, 2'd0, 27'h0, 8'h00, 6'd0, 1);
    cw(0, 27'h0, D_SUSP, 0);
    send(FBC_READ, 2'd0, 27'h0c0_0012, 8'h00, 6'd0, 0);
    chk("read in suspend", 32'(8'h12 ^ 8'h3c), 32'(rd_last));
    send(FBC_MISC, 2'd1, 27'h0, 8'h00, 6'd0, 1);
    cw(0, 27'h0, D_RESUME, 0);
    send(FBC_MISC, 2'd2, 27'h0, 8'h00, 6'd0, 3);
    cw(2, 27'haaa, D_SECSI);
    send(FBC_MISC, 2'd3, 27'h0, 8'h00, 6'd0, 4);
    cw(2, 27'haaa, D_AUTOSEL);
    cw(3, 27'h0, D_ZERO, 0);
    send(FBC_CFI, 2'd0, 27'h0, 8'h00, 6'd0, 1);
    cw(0, 27'h0aa, D_CFI);
  endtask
  task automatic t_reads();
    logic [7:0] exp [0:3] = '{MFR, 8'h1e ^ 8'h3c, 8'h00, 8'h80};
    int r0;
    for (int s = 0; s < 4; s++) begin
      r0 = rd_cnt;
      send(FBC_AUTOSEL, 2'(s), 27'h340_0000, 8'h00, 6'd0, 3);
      cw(2, 27'haaa, D_AUTOSEL);
      chk("read count", (s == 1) ? 3 : 1, 32'(rd_cnt - r0));
      chk("id data", 32'(exp[s]), 32'(rd_last));
      send(FBC_RESET, 2'd0, 27'h0, 8'h00, 6'd0, 1);
      cw(0, 27'h0, D_RESET, 0);
    end
    send(FBC_READ, 2'd0, 27'h0c0_0047, 8'h00, 6'd0, 0);
    chk("array data", 32'(8'h47 ^ 8'h3c), 32'(rd_last));
  endtask
  task automatic t_reset();
    req = '{op: FBC_PROG, sub: 2'd0, addr: 27'h0, data: 8'h00, count: 6'd0};
    req_valid = 1'b1;
    @(posedge clk_sys) #1;
    req_valid = 1'b0;
    while (fl_we_n !== 1'b0) @(posedge clk_sys) #1;
    arst_n = 1'b0;
    #1;
    chk("pins in reset", 32'h3a, 32'({fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe, req_ready, rd_valid}));
    chk("address in reset", 32'h0, 32'(fl_addr));
    @(posedge clk_sys) #1;
    arst_n = 1'b1;
    send(FBC_CFI, 2'd0, 27'h0, 8'h00, 6'd0, 1);
    cw(0, 27'h0aa, D_CFI);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    t_program_erase();
    t_buffer();
    t_bypass_misc();
    t_reads();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
